// File: flash_lane_io.sv
// Device-side serial flash lane mapping, protection and register slave.
//
// Added by the designer: the address map and the AXI4-Lite slave port.
module flash_lane_io
  import flash_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        S_N_I,
  input  wire logic        SCK_I,
  input  wire logic [3:0]  DQ_I,
  output logic      [3:0]  DQ_O,
  output logic      [3:0]  DQ_OE_O,
  input  wire logic [7:0]  AXI_AWADDR_I,
  input  wire logic        AXI_AWVALID_I,
  output logic             AXI_AWREADY_O,
  input  wire logic [31:0] AXI_WDATA_I,
  input  wire logic [3:0]  AXI_WSTRB_I,
  input  wire logic        AXI_WVALID_I,
  output logic             AXI_WREADY_O,
  output logic [1:0]       AXI_BRESP_O,
  output logic             AXI_BVALID_O,
  input  wire logic        AXI_BREADY_I,
  input  wire logic [7:0]  AXI_ARADDR_I,
  input  wire logic        AXI_ARVALID_I,
  output logic             AXI_ARREADY_O,
  output logic [31:0]      AXI_RDATA_O,
  output logic [1:0]       AXI_RRESP_O,
  output logic             AXI_RVALID_O,
  input  wire logic        AXI_RREADY_I
);

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        aw_held;
    logic [7:0]  awaddr;
    logic        w_held;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    proto_t      proto;
    logic        dtr;
    logic        hold_en;
    logic [7:0]  sreg;
    logic [7:0]  txd;
    logic        overflow;
    logic        refused;
    logic [15:0] busy_cnt;
    logic        sck_d;
    logic        cs_d;
    phase_t      ph;
    lanes_t      lanes;
    logic [7:0]  opcode;
    logic [7:0]  sh;
    logic [3:0]  bitcnt;
    logic        first_data;
    logic        wrsr_ok;
    logic [7:0]  wrsr_val;
    logic        push_pend;
    logic [7:0]  push_data;
    logic [3:0]  dq_o;
    logic [3:0]  dq_oe;
  } state_t;

  state_t      st_r;
  state_t      n;
  logic [5:0]  sync_q;
  logic        cs_s;
  logic        sck_s;
  logic [3:0]  dq_s;
  logic        rise;
  logic        fall;
  logic        hold_act;
  logic        locked;
  logic        busy;
  logic        active;
  logic        sample_ev;
  logic        drive_ev;
  logic        rx_pop;
  logic        byte_done;
  logic [7:0]  sr_view;
  logic [3:0]  step;

  stream_if #(.W(FIFO_WIDTH)) rx_in ();
  stream_if #(.W(FIFO_WIDTH)) rx_out ();

  // ---------------------------------------------------------------------------
  // Lane helpers.
  // ---------------------------------------------------------------------------
  function automatic lanes_t proto_lanes(input proto_t p);
    case (p)
      PROTO_DUAL: proto_lanes = LANE_X2;
      PROTO_QUAD: proto_lanes = LANE_X4;
      default:    proto_lanes = LANE_X1;
    endcase
  endfunction

  // Extended protocol widens only for dual or quad opcodes; the other
  // protocols keep their own width for the whole command.
  function automatic lanes_t op_lanes(input proto_t p, input logic [7:0] op);
    op_lanes = proto_lanes(p);
    if (p == PROTO_EXT) begin
      if (op == OP_QUAD_OUT_READ || op == OP_QUAD_IO_READ || op == OP_QUAD_PROG) begin
        op_lanes = LANE_X4; // R3 R6
      end else if (op == OP_DUAL_OUT_READ || op == OP_DUAL_IO_READ || op == OP_DUAL_PROG) begin
        op_lanes = LANE_X2; // R5
      end
    end
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_READ) || (op == OP_RDSR) || (op == OP_DUAL_OUT_READ) ||
              (op == OP_DUAL_IO_READ) || (op == OP_QUAD_OUT_READ) || (op == OP_QUAD_IO_READ);
  endfunction

  // Single lane drives only lane one; dual and quad drive their whole group.
  function automatic logic [3:0] oe_mask(input lanes_t l);
    case (l)
      LANE_X2: oe_mask = OE_X2; // R5
      LANE_X4: oe_mask = OE_X4; // R6
      default: oe_mask = OE_X1; // R4
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisation and edge detection.
  // ---------------------------------------------------------------------------
  bit_sync #(.W(SYNC_W)) u_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RESET_N_I),
    .d_i     ({S_N_I, SCK_I, DQ_I}),
    .q_o     (sync_q)
  );

  // Edges are seen two system cycles late after the synchroniser, so the link clock must stay well
  // below a quarter of the system clock.
  assign cs_s  = sync_q[5];
  assign sck_s = sync_q[4];
  assign dq_s  = sync_q[3:0];
  assign rise  = sck_s && !st_r.sck_d;
  assign fall  = !sck_s && st_r.sck_d;
  assign busy  = (st_r.busy_cnt != 16'h0);

  // Hold shares lane three, so it is dropped whenever that lane may carry data.
  assign hold_act = st_r.hold_en && !cs_s && !dq_s[3] && (st_r.proto != PROTO_QUAD) &&
                    !st_r.dtr && (st_r.lanes != LANE_X4); // R1 R9
  // In quad protocol the protect pin is a data lane and never locks.
  assign locked = st_r.sreg[SR_LOCK_BIT] && !dq_s[2] && (st_r.proto != PROTO_QUAD); // R2 R3
  assign active = !cs_s && (st_r.ph != PH_IDLE) && !hold_act; // R8 R9
  assign sample_ev = active && (st_r.ph == PH_CMD || st_r.ph == PH_IN) &&
                     (rise || (st_r.dtr && fall)); // R10
  assign drive_ev = active && (st_r.ph == PH_OUT) && (fall || (st_r.dtr && rise)); // R10
  assign sr_view = {st_r.sreg[7:1], busy};

  // ---------------------------------------------------------------------------
  // Next state.
  // ---------------------------------------------------------------------------
  always_comb begin
    n         = st_r;
    rx_pop    = 1'b0;
    byte_done = 1'b0;
    step      = (st_r.lanes == LANE_X4) ? 4'h4 : (st_r.lanes == LANE_X2) ? 4'h2 : 4'h1;

    // Write address and data may arrive in either order; the write runs
    // once both are held and no response is outstanding.
    if (AXI_AWVALID_I && st_r.awready) begin
      n.aw_held = 1'b1;
      n.awaddr  = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && st_r.wready) begin
      n.w_held = 1'b1;
      n.wdata  = AXI_WDATA_I[7:0];
      n.wstrb0 = AXI_WSTRB_I[0];
    end
    if (st_r.bvalid && AXI_BREADY_I) begin
      n.bvalid = 1'b0;
    end
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_OKAY;
      case (st_r.awaddr)
        ADDR_CTRL: if (st_r.wstrb0) begin
          n.proto   = (st_r.wdata[1:0] == 2'h1) ? PROTO_DUAL :
                      (st_r.wdata[1:0] == 2'h2) ? PROTO_QUAD : PROTO_EXT;
          n.dtr     = st_r.wdata[CTRL_DTR_BIT];
          n.hold_en = st_r.wdata[CTRL_HOLD_EN_BIT];
        end
        ADDR_STATUS: if (st_r.wstrb0) begin
          if (st_r.wdata[ST_OVERFLOW]) n.overflow = 1'b0;
          if (st_r.wdata[ST_REFUSED]) n.refused = 1'b0;
        end
        ADDR_SREG: if (st_r.wstrb0) begin
          n.sreg = st_r.wdata;
        end
        ADDR_TXDATA: if (st_r.wstrb0) begin
          n.txd = st_r.wdata;
        end
        ADDR_RXDATA: begin
        end
        default: begin
          n.bresp = RESP_SLVERR;
        end
      endcase
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready  = !n.w_held && !n.bvalid;

    // Reads answer one cycle after the address is taken; a read of the
    // receive register pops the FIFO head.
    if (st_r.rvalid && AXI_RREADY_I) begin
      n.rvalid = 1'b0;
    end
    if (AXI_ARVALID_I && st_r.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = '0;
      case (AXI_ARADDR_I)
        ADDR_CTRL: begin
          n.rdata[1:0]              = st_r.proto;
          n.rdata[CTRL_DTR_BIT]     = st_r.dtr;
          n.rdata[CTRL_HOLD_EN_BIT] = st_r.hold_en;
        end
        ADDR_STATUS: begin
          n.rdata[ST_WIP]      = busy;
          n.rdata[ST_SELECTED] = !cs_s;
          n.rdata[ST_HOLD]     = hold_act;
          n.rdata[ST_WP_LEVEL] = dq_s[2];
          n.rdata[ST_LOCKED]   = locked;
          n.rdata[ST_OVERFLOW] = st_r.overflow;
          n.rdata[ST_REFUSED]  = st_r.refused;
          n.rdata[ST_RX_AVAIL] = rx_out.valid;
          n.rdata[ST_STANDBY]  = cs_s && !busy; // R8
        end
        ADDR_SREG:   n.rdata[7:0] = sr_view;
        ADDR_TXDATA: n.rdata[7:0] = st_r.txd;
        ADDR_RXDATA: begin
          n.rdata[7:0]          = rx_out.data;
          n.rdata[RX_VALID_BIT] = rx_out.valid;
          rx_pop                = rx_out.valid;
        end
        default: begin
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    n.arready = !n.rvalid;

    // The internal status-write cycle runs on whatever select does.
    n.sck_d = sck_s;
    n.cs_d  = cs_s;
    if (busy) begin
      n.busy_cnt = st_r.busy_cnt - 16'h1; // R8
    end
    if (st_r.push_pend && rx_in.ready) begin
      n.push_pend = 1'b0;
    end

    if (cs_s) begin
      // Deselected: standby, and a complete status write is applied now, or refused if locked or busy.
      n.ph = PH_IDLE; // R8
      if (!st_r.cs_d && st_r.wrsr_ok) begin
        n.wrsr_ok = 1'b0;
        if (locked || busy) begin
          n.refused = 1'b1; // R2
        end else begin
          n.sreg     = (st_r.sreg & ~SR_NV_MASK) | (st_r.wrsr_val & SR_NV_MASK);
          n.busy_cnt = WRSR_BUSY_CYCLES;
        end
      end
    end else if (st_r.cs_d) begin
      n.ph         = PH_CMD;
      n.bitcnt     = 4'h0;
      n.lanes      = proto_lanes(st_r.proto);
      n.opcode     = 8'h00;
      n.first_data = 1'b1;
      n.wrsr_ok    = 1'b0;
    end else if (sample_ev) begin
      case (st_r.lanes)
        LANE_X4: n.sh = {st_r.sh[3:0], dq_s};          // R6
        LANE_X2: n.sh = {st_r.sh[5:0], dq_s[1:0]};     // R5
        default: n.sh = {st_r.sh[6:0], dq_s[0]};       // R4
      endcase
      n.bitcnt = st_r.bitcnt + step;
      if (n.bitcnt == BITS_PER_BYTE) begin
        byte_done = 1'b1;
        n.bitcnt  = 4'h0;
        if (st_r.ph == PH_CMD) begin
          n.opcode = n.sh;
          n.lanes  = op_lanes(st_r.proto, n.sh);
          if (is_read(n.sh)) begin
            n.ph = PH_OUT;
            n.sh = (n.sh == OP_RDSR) ? sr_view : st_r.txd;
          end else begin
            n.ph = PH_IN;
          end
        end else begin
          if (st_r.opcode == OP_WRSR && st_r.first_data) begin
            n.wrsr_ok  = 1'b1;
            n.wrsr_val = n.sh;
          end
          n.first_data = 1'b0;
        end
      end
    end else if (drive_ev) begin
      case (st_r.lanes)
        LANE_X4: n.dq_o = st_r.sh[7:4];                  // R3 R6
        LANE_X2: n.dq_o = {2'b00, st_r.sh[7:6]};         // R5
        default: n.dq_o = {2'b00, st_r.sh[7], 1'b0};     // R4
      endcase
      n.sh     = st_r.sh << step;
      n.bitcnt = st_r.bitcnt + step;
      if (n.bitcnt == BITS_PER_BYTE) begin
        n.bitcnt = 4'h0;
        n.sh     = (st_r.opcode == OP_RDSR) ? sr_view : st_r.txd;
      end
    end

    // Every received byte is offered to the FIFO; a byte that finds the slot
    // still taken is dropped, since the link itself cannot be stalled.
    if (byte_done) begin
      if (n.push_pend) begin
        n.overflow = 1'b1;
      end else begin
        n.push_pend = 1'b1;
        n.push_data = n.sh;
      end
    end

    n.dq_oe = (n.ph == PH_OUT && !cs_s && !hold_act) ? oe_mask(n.lanes) : OE_NONE; // R8 R9
  end

  // ---------------------------------------------------------------------------
  // Registers and outputs.
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_r      <= '0;
      st_r.sreg <= SR_RESET;
      st_r.txd  <= TX_RESET;
    end else begin
      st_r <= n;
    end
  end

  stream_fifo #(.W(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i   (CLOCK_I),
    .rst_n_i (RESET_N_I),
    .in_s    (rx_in),
    .out_s   (rx_out)
  );

  assign rx_in.valid   = st_r.push_pend;
  assign rx_in.data    = st_r.push_data;
  assign rx_out.ready  = rx_pop;
  assign DQ_O          = st_r.dq_o;
  assign DQ_OE_O       = st_r.dq_oe;
  assign AXI_AWREADY_O = st_r.awready;
  assign AXI_WREADY_O  = st_r.wready;
  assign AXI_BRESP_O   = st_r.bresp;
  assign AXI_BVALID_O  = st_r.bvalid;
  assign AXI_ARREADY_O = st_r.arready;
  assign AXI_RDATA_O   = st_r.rdata;
  assign AXI_RRESP_O   = st_r.rresp;
  assign AXI_RVALID_O  = st_r.rvalid;

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);

  AST_HOLD_IGNORED: assert property ( // R1
    (st_r.proto == PROTO_QUAD && n.ph == PH_OUT && !cs_s && !dq_s[3]) |=> DQ_OE_O == 4'hF)
    else $error("Hold acted in quad protocol.");
  AST_WRSR_LOCKED: assert property ( // R2
    (cs_s && !st_r.cs_d && st_r.wrsr_ok && locked && !st_r.aw_held)
    |=> (st_r.sreg == $past(st_r.sreg)) && st_r.refused)
    else $error("Locked status register was written.");
  AST_DQ2_DATA: assert property ( // R3
    (n.ph == PH_OUT && n.lanes == LANE_X4 && !cs_s) |=> DQ_OE_O[2])
    else $error("Lane two not driven in quad output.");
  AST_X1_LANES: assert property ( // R4
    (n.lanes == LANE_X1) |=> (DQ_OE_O[3:2] == 2'b00) && !DQ_OE_O[0])
    else $error("Single lane drove a lane other than one.");
  AST_X2_LANES: assert property ( // R5
    (n.lanes == LANE_X2) |=> DQ_OE_O[3:2] == 2'b00)
    else $error("Dual command drove lanes two or three.");
  AST_X4_IN: assert property ( // R6
    (sample_ev && st_r.ph == PH_IN && st_r.lanes == LANE_X4) |=> st_r.sh[3:0] == $past(dq_s))
    else $error("Quad input not taken from all lanes.");
  AST_STANDBY_OFF: assert property ( // R8
    cs_s |=> DQ_OE_O == 4'h0)
    else $error("Outputs driven while deselected.");
  AST_BUSY_RUNS: assert property ( // R8
    (cs_s && st_r.busy_cnt != 16'h0) |=> st_r.busy_cnt == $past(st_r.busy_cnt) - 16'h1)
    else $error("Busy cycle stopped in standby.");
  AST_HOLD_PAUSE: assert property ( // R9
    (hold_act && !st_r.cs_d) |=> (DQ_OE_O == 4'h0) && (st_r.bitcnt == $past(st_r.bitcnt)))
    else $error("Transfer moved during hold.");
  AST_DTR_SAMPLE: assert property ( // R10
    (st_r.dtr && fall && active && st_r.ph == PH_CMD)
    |=> (st_r.bitcnt != $past(st_r.bitcnt)) || (st_r.ph != PH_CMD))
    else $error("Falling edge not sampled in DTR.");
  AST_DTR_DRIVE: assert property ( // R10
    (st_r.dtr && rise && active && st_r.ph == PH_OUT && st_r.lanes == LANE_X4)
    |=> DQ_O == $past(st_r.sh[7:4]))
    else $error("Rising edge did not drive data in DTR.");

  COV_WRSR_DONE: cover property (cs_s && !st_r.cs_d && st_r.wrsr_ok && !locked && !busy);
  COV_QUAD_OUT:  cover property (DQ_OE_O == 4'hF);
  COV_OVERFLOW:  cover property (n.overflow && !st_r.overflow);
  COV_HOLD:      cover property (hold_act && st_r.ph == PH_OUT);

endmodule

// File: flash_pkg.sv
// Shared constants, types and register map of the serial flash lane block.
package flash_pkg;

  // How it works
  // R1: Hold ignored in quad protocol or DTR.
  // R2: Lock bit and low protect pin block status writes.
  // R3: Protect pin becomes lane two during quad transfers.
  // R4: Single commands: lane zero in, lane one out.
  // R5: Dual commands: lanes zero and one bidirectional.
  // R6: Quad commands: all four lanes bidirectional.
  // R7: Host drives the protect pin level except during quad output, when the device drives lane two.
  // R8: Select high: standby, outputs off, busy continues.
  // R9: Hold pauses transfer, outputs off, inputs ignored.
  // R10: DTR samples and drives on both clock edges.

  // ---------------------------------------------------------------------------
  // Register map.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SREG   = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0C;
  localparam logic [7:0] ADDR_RXDATA = 8'h10;

  localparam int CTRL_DTR_BIT     = 2;
  localparam int CTRL_HOLD_EN_BIT = 3;
  localparam int ST_WIP           = 0;
  localparam int ST_SELECTED      = 1;
  localparam int ST_HOLD          = 2;
  localparam int ST_WP_LEVEL      = 3;
  localparam int ST_LOCKED        = 4;
  localparam int ST_OVERFLOW      = 5;
  localparam int ST_REFUSED       = 6;
  localparam int ST_RX_AVAIL      = 7;
  localparam int ST_STANDBY       = 8;
  localparam int RX_VALID_BIT     = 8;
  localparam int SR_LOCK_BIT      = 7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Reset values, counts and link encodings.
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  SR_RESET         = 8'h00;
  localparam logic [7:0]  SR_NV_MASK       = 8'hFC;
  localparam logic [7:0]  TX_RESET         = 8'hFF;
  localparam logic [15:0] WRSR_BUSY_CYCLES = 16'h0040;
  localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
  localparam int          FIFO_DEPTH       = 16;
  localparam int          FIFO_WIDTH       = 8;
  localparam int          SYNC_W           = 6;

  localparam logic [7:0] OP_WRSR           = 8'h01;
  localparam logic [7:0] OP_READ           = 8'h03;
  localparam logic [7:0] OP_RDSR           = 8'h05;
  localparam logic [7:0] OP_DUAL_OUT_READ  = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_READ   = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT_READ  = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO_READ   = 8'hEB;
  localparam logic [7:0] OP_DUAL_PROG      = 8'hA2;
  localparam logic [7:0] OP_QUAD_PROG      = 8'h32;

  localparam logic [3:0] OE_NONE = 4'h0;
  localparam logic [3:0] OE_X1   = 4'h2;
  localparam logic [3:0] OE_X2   = 4'h3;
  localparam logic [3:0] OE_X4   = 4'hF;

  typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;
  typedef enum logic [1:0] {LANE_X1, LANE_X2, LANE_X4} lanes_t;
  typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_IN, PH_OUT} phase_t;

endpackage

// File: stream_if.sv
// Valid/ready byte stream between the lane logic and its receive FIFO.
interface stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: bit_sync.sv
// Two-stage synchroniser for a group of independent pin levels.
module bit_sync #(parameter int W = 1) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // The first stage feeds only the second; nothing else looks at it.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  // Both stages clear under reset.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule

// File: stream_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
module stream_fifo #(parameter int W = 8, parameter int DEPTH = 16) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  stream_if.snk     in_s,
  stream_if.src     out_s
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } fifo_t;

  fifo_t st_r;
  fifo_t st_nxt;
  logic  push;
  logic  pop;

  // Full and empty come straight from the stored count.
  assign in_s.ready  = (st_r.cnt != CW'(DEPTH));
  assign out_s.valid = (st_r.cnt != '0);
  assign out_s.data  = st_r.mem[st_r.rp];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // Pointers wrap explicitly so that a depth other than a power of two works.
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_s.data;
      st_nxt.wp = (st_r.wp == PW'(DEPTH - 1)) ? '0 : st_r.wp + PW'(1);
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == PW'(DEPTH - 1)) ? '0 : st_r.rp + PW'(1);
    end
    st_nxt.cnt = st_r.cnt + CW'(push) - CW'(pop);
  end

  // Storage and pointers clear under reset.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// File: spi_host.sv
// Behavioural SPI host that drives select, clock and lanes.
module spi_host (
  output logic            s_n_o,
  output logic            sck_o,
  output logic      [3:0] dq_o,
  input  wire logic [3:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Pin driving.
  // ---------------------------------------------------------------------------
  // The clock starts low and rests high after each xfer; every lane is driven since the pins have no pull-up.
  initial begin
    s_n_o = 1'b1;
    sck_o = 1'b0;
    dq_o  = 4'hF;
  end
  // Odd delay keeps host edges away from the system clock edges.
  task automatic cs(input logic v);
    #43;
    s_n_o = v;
    #60;
  endtask
  task automatic set(input int j, input logic v);
    dq_o[j] = v;
  endtask
  // One byte MSB first, w lanes a step; x1 answers come back on lane one.
  task automatic xfer(input logic [7:0] d, input int w, output logic [7:0] r);
    for (int i = 0; i < 8 / w; i++) begin
      sck_o = 1'b0;
      for (int j = 0; j < w; j++) dq_o[j] = d[8 - (i + 1) * w + j];
      #39;
      for (int j = 0; j < w; j++) r[8 - (i + 1) * w + j] = pin_i[(w == 1) ? 1 : j];
      #1;
      sck_o = 1'b1;
      #40;
    end
  endtask
  // DTR moves one step a clock edge; lanes change an eighth of a period ahead.
  task automatic xdtr(input logic [7:0] d, input int w, output logic [7:0] r);
    for (int i = 0; i < 8 / w; i++) begin
      for (int j = 0; j < w; j++) dq_o[j] = d[8 - (i + 1) * w + j];
      #10 sck_o = ~sck_o;
      #30;
      for (int j = 0; j < w; j++) r[8 - (i + 1) * w + j] = pin_i[(w == 1) ? 1 : j];
    end
  endtask
endmodule

// File: flash_lane_io_tb.sv
// Self-checking bench for the flash lane block.
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module flash_lane_io_tb
  import flash_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, s_n, sck;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, r, v;
  logic [31:0] wdata, rd, rdata, seed;
  logic [1:0]  bresp, rresp, rsp;
  logic [3:0]  dq_o, dq_oe, hdq, pin, wstrb;
  int          n_fail, tests_run;
  // Each lane shows the device while it drives, otherwise the host.
  assign pin = (dq_oe & dq_o) | (~dq_oe & hdq);
  flash_lane_io u_dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .S_N_I(s_n), .SCK_I(sck),
    .DQ_I(pin), .DQ_O(dq_o), .DQ_OE_O(dq_oe), .AXI_AWADDR_I(awaddr),
    .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata),
    .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
    .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
    .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
    .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid),
    .AXI_RREADY_I(rready));
  spi_host u_host (.s_n_o(s_n), .sck_o(sck), .dq_o(hdq), .pin_i(pin));
  // ---------------------------------------------------------------------------
  // Bus tasks, random source and verdict.
  // ---------------------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A hang costs one mismatch; the whole sequence needs far less than this.
  initial begin
    #400000;
    n_fail++;
    test_done;
  end
  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    n_fail = 0;
    tests_run = 0;
    seed = 32'h5CFE48E4;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // Reset value of the transmit register and an unmapped place on both channels.
    wstrb <= 4'h0;
    axw(ADDR_TXDATA, 32'h0);
    wstrb <= 4'hF;
    axr(ADDR_TXDATA);
    `CHK("txdata", {24'h0, TX_RESET}, rd)
    axr(8'h20);
    `CHK("rresp", RESP_SLVERR, rsp)
    axw(8'h20, 32'h1);
    `CHK("bresp", RESP_SLVERR, rsp)
    // Status write over lane zero with a random value, then the busy time.
    seed = xs(seed);
    v = seed[7:0] & 8'h7F;
    u_host.cs(1'b0);
    u_host.xfer(OP_WRSR, 1, r);
    u_host.xfer(v, 1, r);
    u_host.cs(1'b1);
    axr(ADDR_SREG);
    `CHK("busy", 1'b1, rd[0])
    `CHK("oe idle", OE_NONE, dq_oe)
    repeat (80) @(posedge clk);
    axr(ADDR_SREG);
    `CHK("sreg", {24'h0, v & SR_NV_MASK}, rd)
    axr(ADDR_STATUS);
    `CHK("standby", 1'b1, rd[ST_STANDBY])
    axr(ADDR_RXDATA);
    `CHK("rx op", {1'b1, OP_WRSR}, rd[8:0])
    axr(ADDR_RXDATA);
    `CHK("rx val", {1'b1, v}, rd[8:0])
    // Lock bit with the protect pin low: the write must be refused.
    axw(ADDR_SREG, 32'h80);
    u_host.set(2, 1'b0);
    u_host.cs(1'b0);
    u_host.xfer(OP_WRSR, 1, r);
    u_host.xfer(~v, 1, r);
    u_host.cs(1'b1);
    u_host.set(2, 1'b1);
    axr(ADDR_SREG);
    `CHK("locked", 32'h80, rd)
    axr(ADDR_STATUS);
    `CHK("refused", 1'b1, rd[ST_REFUSED])
    // Status read on lane one, paused by hold in mid-frame.
    axw(ADDR_CTRL, 32'h8);
    u_host.cs(1'b0);
    u_host.xfer(OP_RDSR, 1, r);
    u_host.set(3, 1'b0);
    #200;
    `CHK("oe hold", OE_NONE, dq_oe)
    u_host.set(3, 1'b1);
    #200;
    u_host.xfer(8'h00, 1, r);
    `CHK("oe x1", OE_X1, dq_oe)
    `CHK("rdsr", 8'h80, r)
    u_host.cs(1'b1);
    // Quad protocol with hold enabled: lane three low must not pause.
    seed = xs(seed);
    axw(ADDR_TXDATA, {24'h0, seed[7:0]});
    axw(ADDR_CTRL, 32'hA);
    u_host.cs(1'b0);
    u_host.xfer(OP_QUAD_OUT_READ, 4, r);
    u_host.xfer(8'hFF, 4, r);
    `CHK("oe x4", OE_X4, dq_oe)
    `CHK("quad", seed[7:0], r)
    u_host.cs(1'b1);
    // Dual output read in extended protocol.
    axw(ADDR_CTRL, 32'h0);
    u_host.cs(1'b0);
    u_host.xfer(OP_DUAL_OUT_READ, 1, r);
    u_host.xfer(8'hFF, 2, r);
    `CHK("oe x2", OE_X2, dq_oe)
    `CHK("dual", seed[7:0], r)
    u_host.cs(1'b1);
    // DTR: quad output read, then a quad input frame in extended protocol.
    axw(ADDR_CTRL, 32'h4);
    u_host.cs(1'b0);
    u_host.xdtr(OP_QUAD_OUT_READ, 1, r);
    u_host.xdtr(8'hFF, 4, r);
    `CHK("dtr", seed[7:0], r)
    u_host.cs(1'b1);
    u_host.cs(1'b0);
    u_host.xdtr(OP_QUAD_PROG, 1, r);
    u_host.xdtr(v, 4, r);
    u_host.cs(1'b1);
    repeat (8) axr(ADDR_RXDATA);
    `CHK("rx x4", {1'b1, v}, rd[8:0])
    test_done;
  end
endmodule
